// ### rtl/timer_block_ctrl.sv
// Timer block control, clock routing and capture-mode channel logic
`timescale 1ns/1ps
// Functional notes
// - Block sync bit triggers all channels together
// - Ext clock 0 route: pin0, none, A1, A2
// - Ext clock 1 route: pin1, none, A0, A2
// - Ext clock 2 route: pin2, none, A0, A1
// - Enable command starts clock unless disable set
// - Disable command stops clock, beats enable
// - Software trigger zeroes counter, starts clock
// - Clock source: prescaled master or external
// - Invert bit counts on falling edge
// - Gating field ANDs with external clock
// - B load stops clock when enabled
// - B load disables clock when enabled
// - Trigger edge: none, rise, fall, both
// - Trigger from line B or line A
// - C match triggers when enabled
// - Mode bit set selects waveform, no capture
// - A loads counter on chosen line A edge
// - B loads counter on chosen line A edge
module timer_block_ctrl #(
    parameter int CNT_W = timer_block_pkg::CNT_W
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [2:0] clock_pin,
    input wire logic [2:0] channel_line_a,
    input wire logic [2:0] channel_line_b
);
    localparam int NCH = timer_block_pkg::NUM_CHAN;
    localparam int CW = timer_block_pkg::CFG_W;

    ////////////////////////////////////////////////////////////////////////
    // Whole block state in one record
    typedef struct packed {
        logic bus_wait; // Avalon waitrequest
        logic [31:0] rdata; // Avalon read data
        logic [timer_block_pkg::PRESC_W-1:0] presc; // Master clock divider
        logic [timer_block_pkg::ROUTE_W-1:0] route; // Block clock routing
        logic [NCH-1:0][CW-1:0] cfg; // Capture configuration
        logic [NCH-1:0][CNT_W-1:0] cnt; // Counter value
        logic [NCH-1:0][CNT_W-1:0] cap_a; // Capture register A
        logic [NCH-1:0][CNT_W-1:0] cap_b; // Capture register B
        logic [NCH-1:0][CNT_W-1:0] cmp_c; // Compare register C
        logic [NCH-1:0] clk_on; // Counter clock enabled
        logic [NCH-1:0] clk_stop; // Counter clock stopped
        logic [NCH-1:0] gclk_prev; // Gated clock, last cycle
    } blk_t;

    blk_t blk_ff; // Registered state
    blk_t nxt_blk; // Next state

    // Filtered pins: {line_b, line_a, clock_pin}
    logic [8:0] pin_lvl;
    logic [8:0] pin_rise;
    logic [8:0] pin_fall;

    // Decoded events, all but acc and wr_go also watched by the checks below
    logic acc; // Request completes this edge
    logic wr_go; // Write takes effect this edge
    logic sync_go; // Block trigger
    logic [2:0] ext_clk; // Routed external clocks
    logic [NCH-1:0] cmd_en;
    logic [NCH-1:0] cmd_dis;
    logic [NCH-1:0] cmd_sw;
    logic [NCH-1:0] trig;
    logic [NCH-1:0] load_a;
    logic [NCH-1:0] load_b;
    logic [NCH-1:0] tick;

    ////////////////////////////////////////////////////////////////////////
    // Pin conditioning
    pin_filter #(
        .WIDTH(9)
    ) u_pins (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in({channel_line_b, channel_line_a, clock_pin}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // One routed external clock
    function automatic logic route_pick(input logic [1:0] code, input logic pin,
                                        input logic line_x, input logic line_y);
        unique case (timer_block_pkg::route_t'(code))
            timer_block_pkg::ROUTE_PIN: route_pick = pin;
            timer_block_pkg::ROUTE_NONE: route_pick = 1'b0;
            timer_block_pkg::ROUTE_LINE_X: route_pick = line_x;
            timer_block_pkg::ROUTE_LINE_Y: route_pick = line_y;
        endcase
    endfunction

    // Edge qualifier shared by trigger and both loads
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        unique case (timer_block_pkg::edge_sel_t'(sel))
            timer_block_pkg::EDGE_NONE: edge_hit = 1'b0;
            timer_block_pkg::EDGE_RISE: edge_hit = rise;
            timer_block_pkg::EDGE_FALL: edge_hit = fall;
            timer_block_pkg::EDGE_BOTH: edge_hit = rise | fall;
        endcase
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        be_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                be_merge[8*b +: 8] = wd[8*b +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [1:0] ch;
        logic [CW-1:0] c;
        logic src_lvl;
        logic gated;
        logic trg_rise;
        logic trg_fall;
        logic c_match;
        logic [31:0] rd;
        logic [31:0] mw; // Merged write word, sliced below
        nxt_blk = blk_ff;
        ch = address[7:6];
        c = '0;
        src_lvl = 1'b0;
        gated = 1'b0;
        trg_rise = 1'b0;
        trg_fall = 1'b0;
        c_match = 1'b0;
        rd = 32'h0000_0000;
        mw = 32'h0000_0000;
        cmd_en = '0;
        cmd_dis = '0;
        cmd_sw = '0;
        trig = '0;
        load_a = '0;
        load_b = '0;
        tick = '0;

        // Free-running divider feeds all prescaled sources
        nxt_blk.presc = blk_ff.presc + 1'b1;

        // One wait cycle, then a one-cycle ack; idle keeps wait high
        acc = (read | write) & blk_ff.bus_wait;
        wr_go = write & ~blk_ff.bus_wait;
        nxt_blk.bus_wait = ~acc;

        sync_go = wr_go & (address[7:2] == timer_block_pkg::OFF_BLK_CMD[7:2])
            & byteenable[0] & writedata[timer_block_pkg::SYNC_BIT];

        ext_clk[0] = route_pick(blk_ff.route[1:0], pin_lvl[0], pin_lvl[4], pin_lvl[5]);
        ext_clk[1] = route_pick(blk_ff.route[3:2], pin_lvl[1], pin_lvl[3], pin_lvl[5]);
        ext_clk[2] = route_pick(blk_ff.route[5:4], pin_lvl[2], pin_lvl[3], pin_lvl[4]);

        // Block routing write; upper bits dropped
        if (wr_go && address[7:2] == timer_block_pkg::OFF_BLK_ROUTE[7:2]) begin
            mw = be_merge(32'(blk_ff.route), writedata, byteenable);
            nxt_blk.route = mw[timer_block_pkg::ROUTE_W-1:0];
        end

        for (int i = 0; i < NCH; i++) begin
            c = blk_ff.cfg[i];

            // command bits are decoded to pulses, never stored
            if (wr_go && ch == 2'(i) && address[5:2] == timer_block_pkg::OFF_CMD[5:2]
                && byteenable[0]) begin
                cmd_en[i] = writedata[timer_block_pkg::CMD_EN_BIT];
                cmd_dis[i] = writedata[timer_block_pkg::CMD_DIS_BIT];
                cmd_sw[i] = writedata[timer_block_pkg::CMD_SOFT_TRIGGER_CMD_BIT];
            end

            unique case (timer_block_pkg::clk_src_t'(c[timer_block_pkg::CLKS_LSB +: 3]))
                timer_block_pkg::SRC_DIV2: src_lvl = blk_ff.presc[timer_block_pkg::DIV2_BIT];
                timer_block_pkg::SRC_DIV8: src_lvl = blk_ff.presc[timer_block_pkg::DIV8_BIT];
                timer_block_pkg::SRC_DIV32: src_lvl = blk_ff.presc[timer_block_pkg::DIV32_BIT];
                timer_block_pkg::SRC_DIV128: src_lvl = blk_ff.presc[timer_block_pkg::DIV128_BIT];
                timer_block_pkg::SRC_DIV1024:
                    src_lvl = blk_ff.presc[timer_block_pkg::DIV1024_BIT];
                timer_block_pkg::SRC_EXT0: src_lvl = ext_clk[0];
                timer_block_pkg::SRC_EXT1: src_lvl = ext_clk[1];
                timer_block_pkg::SRC_EXT2: src_lvl = ext_clk[2];
            endcase

            // burst gating with an external clock
            unique case (c[timer_block_pkg::BURST_LSB +: 2])
                2'h0: gated = src_lvl;
                2'h1: gated = src_lvl & ext_clk[0];
                2'h2: gated = src_lvl & ext_clk[1];
                2'h3: gated = src_lvl & ext_clk[2];
            endcase
            nxt_blk.gclk_prev[i] = gated;

            // count on rise, or on fall when inverted
            if (c[timer_block_pkg::CLOCK_INVERT_BIT]) begin
                tick[i] = blk_ff.gclk_prev[i] & ~gated;
            end else begin
                tick[i] = ~blk_ff.gclk_prev[i] & gated;
            end
            tick[i] = tick[i] & blk_ff.clk_on[i] & ~blk_ff.clk_stop[i];

            // trigger line is B or A
            if (c[timer_block_pkg::TRGSEL_BIT]) begin
                trg_rise = pin_rise[3 + i];
                trg_fall = pin_fall[3 + i];
            end else begin
                trg_rise = pin_rise[6 + i];
                trg_fall = pin_fall[6 + i];
            end

            // compare match on a counting edge
            c_match = tick[i] & (blk_ff.cnt[i] == blk_ff.cmp_c[i]);

            // capture behaviour only while mode bit is clear
            if (!c[timer_block_pkg::WAVE_BIT]) begin
                load_a[i] = edge_hit(c[timer_block_pkg::A_LOAD_EDGE_SEL_LSB +: 2],
                                     pin_rise[3 + i], pin_fall[3 + i]);
                load_b[i] = edge_hit(c[timer_block_pkg::B_LOAD_EDGE_SEL_LSB +: 2],
                                     pin_rise[3 + i], pin_fall[3 + i]);
            end

            // external trigger edge; waveform event fields not handled here
            trig[i] = sync_go | cmd_sw[i]
                | (~c[timer_block_pkg::WAVE_BIT]
                   & edge_hit(c[timer_block_pkg::ETRG_LSB +: 2], trg_rise, trg_fall))
                | (c_match & c[timer_block_pkg::C_MATCH_TRIGGER_EN_BIT]);

            // trigger zeroes the counter and restarts the clock
            if (trig[i]) begin
                nxt_blk.cnt[i] = '0;
            end else if (tick[i]) begin
                nxt_blk.cnt[i] = blk_ff.cnt[i] + 1'b1;
            end

            // Captures sample the value before this edge's update
            if (load_a[i]) begin
                nxt_blk.cap_a[i] = blk_ff.cnt[i];
            end
            if (load_b[i]) begin
                nxt_blk.cap_b[i] = blk_ff.cnt[i];
            end

            // disable beats enable; disable on B load
            if (cmd_dis[i] || (load_b[i] && c[timer_block_pkg::DISABLE_ON_B_LOAD_BIT])) begin
                nxt_blk.clk_on[i] = 1'b0;
            end else if (cmd_en[i]) begin
                nxt_blk.clk_on[i] = 1'b1;
            end

            // B load stops; a trigger in the same cycle restarts
            if (trig[i]) begin
                nxt_blk.clk_stop[i] = 1'b0;
            end else if (load_b[i] && c[timer_block_pkg::STOP_ON_B_LOAD_BIT]) begin
                nxt_blk.clk_stop[i] = 1'b1;
            end

            if (wr_go && ch == 2'(i) && address[5:2] == timer_block_pkg::OFF_CFG[5:2]) begin
                mw = be_merge(32'(blk_ff.cfg[i]), writedata, byteenable);
                nxt_blk.cfg[i] = mw[CW-1:0] & timer_block_pkg::CFG_MASK[CW-1:0];
            end
            if (wr_go && ch == 2'(i) && address[5:2] == timer_block_pkg::OFF_CMP_C[5:2]) begin
                mw = be_merge(32'(blk_ff.cmp_c[i]), writedata, byteenable);
                nxt_blk.cmp_c[i] = mw[CNT_W-1:0];
            end
        end

        // Read mux; unmapped and write-only words read zero
        if (ch != timer_block_pkg::BLK_SLOT) begin
            unique case (address[5:2])
                timer_block_pkg::OFF_CFG[5:2]: rd = 32'(blk_ff.cfg[ch]);
                timer_block_pkg::OFF_CNT[5:2]: rd = 32'(blk_ff.cnt[ch]);
                timer_block_pkg::OFF_CAP_A[5:2]: rd = 32'(blk_ff.cap_a[ch]);
                timer_block_pkg::OFF_CAP_B[5:2]: rd = 32'(blk_ff.cap_b[ch]);
                timer_block_pkg::OFF_CMP_C[5:2]: rd = 32'(blk_ff.cmp_c[ch]);
                default: rd = 32'h0000_0000;
            endcase
        end else if (address[5:2] == timer_block_pkg::OFF_BLK_ROUTE[5:2]) begin
            rd = 32'(blk_ff.route);
        end
        if (acc && read) begin
            nxt_blk.rdata = rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            blk_ff <= '0;
            blk_ff.bus_wait <= 1'b1;
            blk_ff.route <= timer_block_pkg::ROUTE_RESET;
            blk_ff.cfg <= {NCH{timer_block_pkg::CFG_RESET}};
        end else begin
            blk_ff <= nxt_blk;
        end
    end

    assign readdata = blk_ff.rdata;
    assign waitrequest = blk_ff.bus_wait;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_bus_ack;
        @(posedge ref_clk) disable iff (reset)
        ((read | write) && waitrequest) |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus ack not one cycle");

    property p_sync_all;
        @(posedge ref_clk) disable iff (reset)
        sync_go |=> (blk_ff.cnt[0] == '0 && blk_ff.cnt[1] == '0 && blk_ff.cnt[2] == '0);
    endproperty
    a_sync_all: assert property (p_sync_all) else $error("sync missed a channel");

    property p_route_none;
        @(posedge ref_clk) disable iff (reset)
        (blk_ff.route[1:0] == 2'h1) |-> !ext_clk[0];
    endproperty
    a_route_none: assert property (p_route_none) else $error("ext clock 0 not idle");

    property p_en_cmd;
        @(posedge ref_clk) disable iff (reset)
        (cmd_en[1] && !cmd_dis[1] && !load_b[1]) |=> blk_ff.clk_on[1];
    endproperty
    a_en_cmd: assert property (p_en_cmd) else $error("enable ignored");

    property p_dis_wins;
        @(posedge ref_clk) disable iff (reset)
        cmd_dis[0] |=> !blk_ff.clk_on[0] && !tick[0];
    endproperty
    a_dis_wins: assert property (p_dis_wins) else $error("disable lost");

    property p_sw_trig;
        @(posedge ref_clk) disable iff (reset)
        cmd_sw[0] |=> blk_ff.cnt[0] == '0 && !blk_ff.clk_stop[0];
    endproperty
    a_sw_trig: assert property (p_sw_trig) else $error("soft trigger failed");

    property p_b_stop;
        @(posedge ref_clk) disable iff (reset)
        (load_b[1] && blk_ff.cfg[1][timer_block_pkg::STOP_ON_B_LOAD_BIT] && !trig[1])
            |=> blk_ff.clk_stop[1] ##1 (blk_ff.clk_stop[1] || $past(trig[1]));
    endproperty
    a_b_stop: assert property (p_b_stop) else $error("B load did not stop");

    property p_wave_nocap;
        @(posedge ref_clk) disable iff (reset)
        blk_ff.cfg[0][timer_block_pkg::WAVE_BIT] |-> !load_a[0] && !load_b[0];
    endproperty
    a_wave_nocap: assert property (p_wave_nocap) else $error("capture in waveform");

    property p_cap_a;
        @(posedge ref_clk) disable iff (reset)
        load_a[1] |=> blk_ff.cap_a[1] == $past(blk_ff.cnt[1]);
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("A capture wrong value");

    property p_cmd_zero;
        @(posedge ref_clk) disable iff (reset)
        (read && waitrequest && address[5:2] == 4'h0) |=> readdata == 32'h0000_0000;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command word read nonzero");
endmodule

// ### inc/timer_block_pkg.sv
// Shared constants and types of the three-channel timer control block
package timer_block_pkg;
    // Channel count and counter width
    localparam int NUM_CHAN = 3;
    localparam int CNT_W = 16;
    // Per-channel register offsets inside one channel slot
    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_CFG = 6'h04;
    localparam logic [5:0] OFF_CNT = 6'h10;
    localparam logic [5:0] OFF_CAP_A = 6'h14;
    localparam logic [5:0] OFF_CAP_B = 6'h18;
    localparam logic [5:0] OFF_CMP_C = 6'h1c;
    // Block-level register byte addresses
    localparam logic [7:0] OFF_BLK_CMD = 8'hc0;
    localparam logic [7:0] OFF_BLK_ROUTE = 8'hc4;
    // Channel slot number of the block-level registers
    localparam logic [1:0] BLK_SLOT = 2'h3;
    // Command bits
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_DIS_BIT = 1;
    localparam int CMD_SOFT_TRIGGER_CMD_BIT = 2;
    localparam int SYNC_BIT = 0;
    // Capture configuration field positions
    localparam int CLKS_LSB = 0;
    localparam int CLOCK_INVERT_BIT = 3;
    localparam int BURST_LSB = 4;
    localparam int STOP_ON_B_LOAD_BIT = 6;
    localparam int DISABLE_ON_B_LOAD_BIT = 7;
    localparam int ETRG_LSB = 8;
    localparam int TRGSEL_BIT = 10;
    localparam int C_MATCH_TRIGGER_EN_BIT = 14;
    localparam int WAVE_BIT = 15;
    localparam int A_LOAD_EDGE_SEL_LSB = 16;
    localparam int B_LOAD_EDGE_SEL_LSB = 18;
    localparam int CFG_W = 20;
    // Writable bits; the rest read back as zero
    localparam logic [31:0] CFG_MASK = 32'h000f_c7ff;
    localparam logic [CFG_W-1:0] CFG_RESET = 20'h0_0000;
    // Clock routing: three 2-bit fields
    localparam int ROUTE_W = 6;
    localparam logic [ROUTE_W-1:0] ROUTE_RESET = 6'h00;
    // Prescaler bits giving master clock /2, /8, /32, /128, /1024
    localparam int PRESC_W = 10;
    localparam int DIV2_BIT = 0;
    localparam int DIV8_BIT = 2;
    localparam int DIV32_BIT = 4;
    localparam int DIV128_BIT = 6;
    localparam int DIV1024_BIT = 9;
    // Edge selection codes
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;
    // External clock routing codes
    typedef enum logic [1:0] {
        ROUTE_PIN = 2'h0,
        ROUTE_NONE = 2'h1,
        ROUTE_LINE_X = 2'h2,
        ROUTE_LINE_Y = 2'h3
    } route_t;
    // Clock source codes
    typedef enum logic [2:0] {
        SRC_DIV2 = 3'h0,
        SRC_DIV8 = 3'h1,
        SRC_DIV32 = 3'h2,
        SRC_DIV128 = 3'h3,
        SRC_DIV1024 = 3'h4,
        SRC_EXT0 = 3'h5,
        SRC_EXT1 = 3'h6,
        SRC_EXT2 = 3'h7
    } clk_src_t;
endpackage

// ### rtl/pin_filter.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_filter #(
    parameter int WIDTH = 9
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    ////////////////////////////////////////////////////////////////////////
    // All state in one record
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } filt_t;

    filt_t filt_ff; // Registered state
    filt_t nxt_filt; // Next state

    ////////////////////////////////////////////////////////////////////////
    // Stage one is read only by stage two; level moves when two and three agree
    always_comb begin
        nxt_filt = filt_ff;
        nxt_filt.s1 = pin_in;
        nxt_filt.s2 = filt_ff.s1;
        nxt_filt.s3 = filt_ff.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (filt_ff.s2[i] == filt_ff.s3[i]) begin
                nxt_filt.lvl[i] = filt_ff.s2[i];
            end
        end
        nxt_filt.rise = nxt_filt.lvl & ~filt_ff.lvl;
        nxt_filt.fall = ~nxt_filt.lvl & filt_ff.lvl;
    end

    // Register, cleared synchronously
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            filt_ff <= '0;
        end else begin
            filt_ff <= nxt_filt;
        end
    end

    assign level = filt_ff.lvl;
    assign rise = filt_ff.rise;
    assign fall = filt_ff.fall;
endmodule

// ### bench/line_driver.sv
// Model of the external clock pins and channel lines
`timescale 1ns/1ps
module line_driver (
    input wire logic ref_clk,
    output logic [2:0] clock_pin,
    output logic [2:0] channel_line_a,
    output logic [2:0] channel_line_b
);
    // Index 0-2 clock pins, 3-5 line A, 6-8 line B
    logic [8:0] lines_ff = 9'h000;
    assign clock_pin = lines_ff[2:0];
    assign channel_line_a = lines_ff[5:3];
    assign channel_line_b = lines_ff[8:6];
    ////////////////////////////////////////////////////////////////////
    // One level change, held so it clears the three-flop pin filter
    task automatic level(input int idx, input logic v);
        @(posedge ref_clk) lines_ff[idx] <= v;
        repeat (6) @(posedge ref_clk);
    endtask
    // Slow pulses, high then low
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            level(idx, 1'b1);
            level(idx, 1'b0);
        end
    endtask
endmodule

// ### bench/test_timer_block_ctrl.sv
// Register-level test of the timer block control
`timescale 1ns/1ps
module test_timer_block_ctrl;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [2:0] clock_pin;
    logic [2:0] channel_line_a;
    logic [2:0] channel_line_b;
    logic [31:0] rd; // Last read word
    int n_fail = 0;
    int cmp_count = 0;
    ////////////////////////////////////////////////////////////////////
    // All byte lanes on: partial writes are not under test
    timer_block_ctrl dut (.ref_clk(ref_clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .clock_pin(clock_pin),
        .channel_line_a(channel_line_a), .channel_line_b(channel_line_b));
    line_driver ext (.ref_clk(ref_clk), .clock_pin(clock_pin),
        .channel_line_a(channel_line_a), .channel_line_b(channel_line_b));
    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////
    // Closing report, the single exit of the run
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        q = readdata;
        // A slave that never answers ends the run
        if (i == 40) begin
            n_fail++;
            give_verdict();
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk(what, rd, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence; channel 1 counts pin 0 or a line A pin so counts are exact
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rc("cfg reset", 8'h04, 32'h0);
        rc("route reset", 8'hc4, 32'h0);
        wr(8'h04, 32'hffff_ffff);
        rc("cfg mask", 8'h04, 32'h000f_c7ff);
        wr(8'hc4, 32'hffff_ffff);
        rc("route mask", 8'hc4, 32'h0000_003f);
        wr(8'hc4, 32'h0);
        wr(8'h00, 32'h0000_0007);
        rc("cmd read", 8'h00, 32'h0);
        rc("block cmd read", 8'hc0, 32'h0);
        rc("unmapped", 8'h08, 32'h0);
        $display("Test done: registers");
        // Source external clock 0, enable plus trigger
        wr(8'h44, 32'h5);
        wr(8'h40, 32'h5);
        ext.pulse(0, 5);
        rc("count pin0", 8'h50, 32'h5);
        wr(8'hc4, 32'h1);
        ext.pulse(0, 3);
        rc("route none", 8'h50, 32'h5);
        wr(8'hc4, 32'h2);
        ext.pulse(4, 2);
        rc("route line a1", 8'h50, 32'h7);
        wr(8'hc4, 32'h0);
        // Enable and disable together: disable wins
        wr(8'h40, 32'h3);
        ext.pulse(0, 2);
        rc("disable wins", 8'h50, 32'h7);
        wr(8'h40, 32'h1);
        ext.pulse(0, 1);
        rc("enable", 8'h50, 32'h8);
        $display("Test done: clock routing and commands");
        // Rising trigger on line B, then on line A
        wr(8'h44, 32'h105);
        ext.pulse(7, 1);
        rc("trigger line b", 8'h50, 32'h0);
        wr(8'h44, 32'h505);
        ext.pulse(0, 2);
        ext.pulse(7, 1);
        rc("line b ignored", 8'h50, 32'h2);
        ext.pulse(4, 1);
        rc("trigger line a", 8'h50, 32'h0);
        // Compare C of 3: the fourth edge wraps to zero
        wr(8'h44, 32'h4005);
        wr(8'h5c, 32'h3);
        ext.pulse(0, 4);
        rc("c match", 8'h50, 32'h0);
        ext.pulse(0, 3);
        $display("Test done: triggers");
        // A on rising, B on falling line A edge, disable on B load
        wr(8'h44, 32'h0009_0085);
        ext.pulse(4, 1);
        rc("capture a", 8'h54, 32'h3);
        rc("capture b", 8'h58, 32'h3);
        ext.pulse(0, 2);
        rc("off on b load", 8'h50, 32'h3);
        // Stop on B load, cleared by a software trigger
        wr(8'h44, 32'h0009_0045);
        wr(8'h40, 32'h1);
        ext.pulse(0, 1);
        ext.pulse(4, 1);
        ext.pulse(0, 2);
        rc("stop on b load", 8'h50, 32'h4);
        wr(8'h40, 32'h4);
        ext.pulse(0, 2);
        rc("trigger restarts", 8'h50, 32'h2);
        // Block-wide trigger zeroes the counter
        wr(8'hc0, 32'h1);
        rc("sync", 8'h50, 32'h0);
        $display("Test done: captures and sync");
        // Inverted clock counts only on the falling edge
        wr(8'h44, 32'hd);
        ext.level(0, 1'b1);
        rc("invert rise", 8'h50, 32'h0);
        ext.level(0, 1'b0);
        rc("invert fall", 8'h50, 32'h1);
        // Pin 0 gated by external clock 1, which is pin 1
        wr(8'h44, 32'h25);
        ext.pulse(0, 1);
        rc("gate closed", 8'h50, 32'h1);
        ext.level(1, 1'b1);
        ext.pulse(0, 1);
        ext.level(1, 1'b0);
        rc("gate open", 8'h50, 32'h2);
        // External clock 1 from line A0, clock 2 from line A1
        wr(8'hc4, 32'h38);
        wr(8'h44, 32'h6);
        ext.pulse(3, 1);
        rc("route ext1 a0", 8'h50, 32'h3);
        wr(8'h44, 32'h7);
        ext.pulse(4, 1);
        rc("route ext2 a1", 8'h50, 32'h4);
        // Falling trigger on line B; none in waveform mode
        wr(8'h44, 32'h207);
        ext.level(7, 1'b1);
        rc("rise ignored", 8'h50, 32'h4);
        ext.level(7, 1'b0);
        rc("fall trigger", 8'h50, 32'h0);
        wr(8'h44, 32'h8207);
        ext.pulse(4, 1);
        ext.pulse(7, 1);
        rc("wave no trigger", 8'h50, 32'h1);
        $display("Test done: invert, gating, routes and edges");
        give_verdict();
    end
endmodule
